// >>> hw/sodr_defines.vh
// constants for the sensor output data register bank
`ifndef SODR_DEFINES_VH
`define SODR_DEFINES_VH
`define SODR_ACCEL_X_RESULT 7'h0a
`define SODR_ACCEL_Y_RESULT 7'h0c
`define SODR_ACCEL_Z_RESULT 7'h0e
`define SODR_FIELD_X_RESULT 7'h10
`define SODR_FIELD_Y_RESULT 7'h12
`define SODR_FIELD_Z_RESULT 7'h14
`define SODR_PRESSURE_HIGH_WORD 7'h16
`define SODR_PRESSURE_LOW_BYTE 7'h18
`define SODR_DIE_TEMPERATURE_RESULT 7'h1a
`define SODR_FIRST_ADDR 7'h0a
`define SODR_LAST_ADDR 7'h1a
`define SODR_NUM_REGS 9
`define SODR_IDX_PRESS_LOW 4'h7
`define SODR_IDX_TEMP 4'h8
`define SODR_FRESH_BIT 15
`define SODR_ALARM_BIT 14
`define SODR_DATA_MSB 13
`define SODR_TEMP_MSB 11
`define SODR_LOW_MSB 7
`define SODR_WORD_BITS 16
`define SODR_CMD_WRITE_BIT 15
`define SODR_CMD_ADDR_MSB 14
`define SODR_CMD_ADDR_LSB 8
`define SODR_BIT_CNT_LAST 4'hf
`endif

// >>> hw/sodr_output_regs.v
// serial slave with the sensor output data register bank
`timescale 1ns/100ps
`include "sodr_defines.vh"
module sodr_output_regs (
    input wire core_clk_i,
    input wire rst_i,
    input wire ss_n_i,
    input wire sclk_i,
    input wire mosi_i,
    output wire miso_o,
    input wire sample_we_i,
    input wire [3:0] sample_sel_i,
    input wire [13:0] sample_data_i,
    input wire alarm_active_i,
    output wire [8:0] fresh_o
);

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers, change accepted when stages two and three agree
wire ss_n_lvl;
wire sclk_lvl;
wire mosi_lvl;
wire nxt_ss_n;
wire nxt_sclk;

// select idles high, so reset shows no false frame start
sodr_pin_sync #(
    .IDLE(1'b1)
) u_ss_sync (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .pin_i(ss_n_i),
    .level_o(ss_n_lvl),
    .nxt_level_o(nxt_ss_n)
);

// mode 3 clock idles high between frames
sodr_pin_sync #(
    .IDLE(1'b1)
) u_sclk_sync (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .pin_i(sclk_i),
    .level_o(sclk_lvl),
    .nxt_level_o(nxt_sclk)
);

// data needs no edge preview, only read on clock rise
sodr_pin_sync #(
    .IDLE(1'b0)
) u_mosi_sync (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .pin_i(mosi_i),
    .level_o(mosi_lvl),
    .nxt_level_o()
);

// edges taken one cycle early from the filter's next value
wire frame_start = ss_n_lvl & ~nxt_ss_n;
wire sclk_rise = ~ss_n_lvl & ~sclk_lvl & nxt_sclk;
wire sclk_fall = ~ss_n_lvl & sclk_lvl & ~nxt_sclk;

////////////////////////////////////////////////////////////////////////////////
// register storage
reg [13:0] data_ff [0:`SODR_NUM_REGS-1];
reg [8:0] fresh_ff;
reg [6:0] addr_ff;

// nine registers from the first to the last even address
wire addr_hit = (addr_ff >= `SODR_FIRST_ADDR) && (addr_ff <= `SODR_LAST_ADDR);
// odd addresses up to 0x19 fold onto the even one below; 0x1b reads zero
wire [6:0] addr_off = addr_ff - `SODR_FIRST_ADDR;
wire [3:0] rd_idx = addr_off[4:1];

// reply word for the pending address
reg [15:0] rd_word;
always @* begin
    rd_word = 16'h0000;
    if (addr_hit) begin
        if (rd_idx == `SODR_IDX_PRESS_LOW) begin
            rd_word[`SODR_LOW_MSB:0] = data_ff[rd_idx][`SODR_LOW_MSB:0];
        end else begin
            rd_word[`SODR_DATA_MSB:0] = data_ff[rd_idx];
            rd_word[`SODR_FRESH_BIT] = fresh_ff[rd_idx];
            rd_word[`SODR_ALARM_BIT] = alarm_active_i;
        end
    end
end

// fresh clear taken at frame start, kept even if the frame is cut
wire rd_take = frame_start & addr_hit;
integer i;
// one sampler load per cycle, set beats read clear

always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
        fresh_ff <= 9'h000;
        for (i = 0; i < `SODR_NUM_REGS; i = i + 1) begin
            data_ff[i] <= 14'h0000;
        end
    end else begin
        for (i = 0; i < `SODR_NUM_REGS; i = i + 1) begin
            if (sample_we_i && (sample_sel_i == i[3:0])) begin
                if (i == `SODR_IDX_TEMP) begin
                    data_ff[i] <= {2'h0, sample_data_i[`SODR_TEMP_MSB:0]};
                end else if (i == `SODR_IDX_PRESS_LOW) begin
                    data_ff[i] <= {6'h00, sample_data_i[`SODR_LOW_MSB:0]};
                end else begin
                    data_ff[i] <= sample_data_i;
                end
                fresh_ff[i] <= 1'b1;
            end else if (rd_take && (rd_idx == i[3:0])) begin
                fresh_ff[i] <= 1'b0;
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// serial framing, mode 3, msb first
reg [15:0] tx_ff;
reg [15:0] rx_ff;
reg [3:0] bit_cnt_ff;
reg miso_ff;

always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
        tx_ff <= 16'h0000;
        rx_ff <= 16'h0000;
        bit_cnt_ff <= 4'h0;
        miso_ff <= 1'b0;
        addr_ff <= 7'h00;
    end else begin
        if (frame_start) begin
            // reply holds previously requested word
            // msb shows now and again on the first fall
            tx_ff <= rd_word;
            miso_ff <= rd_word[15];
            bit_cnt_ff <= 4'h0;
        end else if (sclk_fall) begin
            miso_ff <= tx_ff[15];
            tx_ff <= {tx_ff[14:0], 1'b0};
        end
        // data taken on the rising clock edge, mode 3
        if (sclk_rise) begin
            rx_ff <= {rx_ff[14:0], mosi_lvl};
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
            // each read transfer carries the read address for the next frame
            // command bit still one place below its slot; writes ignored
            if ((bit_cnt_ff == `SODR_BIT_CNT_LAST) && !rx_ff[`SODR_CMD_WRITE_BIT - 1]) begin
                addr_ff <= rx_ff[`SODR_CMD_ADDR_MSB - 1:`SODR_CMD_ADDR_LSB - 1];
            end
        end
    end
end

// both outputs straight from registers
assign miso_o = miso_ff;
assign fresh_o = fresh_ff;

endmodule

////////////////////////////////////////////////////////////////////////////////
// three-stage pin synchroniser with agreement filter
// a single-cycle glitch on the pin never reaches the level
module sodr_pin_sync #(
    parameter [0:0] IDLE = 1'b1
) (
    input wire core_clk_i,
    input wire rst_i,
    input wire pin_i,
    output wire level_o,
    output wire nxt_level_o
);

reg [2:0] sync_ff;
reg level_ff;

// stage one feeds nothing but stage two
assign nxt_level_o = (sync_ff[1] == sync_ff[2]) ? sync_ff[2] : level_ff;

// reset holds the idle level, no false edge after reset
always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
        sync_ff <= {3{IDLE}};
        level_ff <= IDLE;
    end else begin
        sync_ff <= {sync_ff[1:0], pin_i};
        level_ff <= nxt_level_o;
    end
end

assign level_o = level_ff;

endmodule

// >>> tb/sodr_host_model.sv
// serial host issuing full duplex words
`timescale 1ns/100ps
module sodr_host (
    input wire clk_i,
    input wire miso_i,
    output reg ss_n_o = 1'b1,
    output reg sclk_o = 1'b1,
    output reg mosi_o = 1'b0
);
    task automatic xfer(input logic [15:0] d, output logic [15:0] q);
        @(posedge clk_i) #1 ss_n_o = 0;
        for (int b = 15; b >= 0; b--) begin
            repeat (9) @(posedge clk_i);
            #1 {sclk_o, mosi_o} = {1'b0, d[b]};
            repeat (5) @(posedge clk_i);
            #1 {q[b], sclk_o} = {miso_i, 1'b1};
        end
        repeat (9) @(posedge clk_i);
        #1 {ss_n_o, mosi_o} = {1'b1, ~mosi_o};
        repeat (9) @(posedge clk_i);
        #1;
    endtask
endmodule

// >>> tb/sodr_output_regs_checker.sv
// port checker for the output register bank
`timescale 1ns/100ps
module sodr_chk (
    input wire core_clk_i,
    input wire rst_i,
    input wire ss_n_i,
    input wire sclk_i,
    input wire miso_o,
    input wire sample_we_i,
    input wire [3:0] sample_sel_i,
    input wire [8:0] fresh_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    sequence s_off; ss_n_i [*8]; endsequence
    property p_set; sample_we_i && sample_sel_i < 9 |=> fresh_o[$past(sample_sel_i)]; endproperty
    a_set: assert property (p_set) else $error("set");
    property p_ign; sample_we_i && sample_sel_i > 8 |=> !(fresh_o & ~$past(fresh_o)); endproperty
    a_ign: assert property (p_ign) else $error("ign");
    property p_why; |(fresh_o & ~$past(fresh_o)) |-> $past(sample_we_i); endproperty
    a_why: assert property (p_why) else $error("why");
    property p_one; $onehot0($past(fresh_o) & ~fresh_o); endproperty
    a_one: assert property (p_one) else $error("one");
    property p_keep; s_off |=> !($past(fresh_o) & ~fresh_o); endproperty
    a_keep: assert property (p_keep) else $error("keep");
    property p_idle; s_off |-> $stable(miso_o); endproperty
    a_idle: assert property (p_idle) else $error("idle");
    property p_hi; (sclk_i && !ss_n_i) [*8] |-> $stable(miso_o); endproperty
    a_hi: assert property (p_hi) else $error("hi");
    property p_rst; $fell(rst_i) |-> !miso_o; endproperty
    a_rst: assert property (p_rst) else $error("rst");
endmodule

// >>> tb/sodr_output_regs_tb_top.sv
// bench for the output register bank
`timescale 1ns/100ps
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin mismatches++; $display("BAD %s %h %h", n, e, s); end end
module sodr_output_regs_tb_top;
    logic core_clk_i = 0, rst_i = 1, sample_we_i = 0, alarm_active_i = 0, ss_n_i, sclk_i, mosi_i, miso_o;
    logic [3:0] sample_sel_i = 4'h0;
    logic [13:0] sample_data_i = 14'h0, m [9] = '{default: 14'h0};
    logic [8:0] fresh_o, fr = 9'h0;
    logic [15:0] q, e = 16'h0;
    logic [23:0] p24 = 24'h0;
    int mismatches = 0, n_checks = 0, k;
    always #10 core_clk_i = ~core_clk_i;
    sodr_output_regs u_dut (.*);
    sodr_host u_host (.clk_i(core_clk_i), .miso_i(miso_o), .ss_n_o(ss_n_i), .sclk_o(sclk_i), .mosi_o(mosi_i));
    task automatic end_of_test;
        if (mismatches == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // full run is near 49000 cycles
    initial begin
        repeat (75000) @(posedge core_clk_i);
        mismatches++;
        end_of_test;
    end
    initial begin
        void'($urandom(32'hc75f));
        repeat (8) @(posedge core_clk_i);
        #1 rst_i = 0;
        repeat (4) @(posedge core_clk_i);
        for (int r = 0; r < 10; r++) begin
            @(posedge core_clk_i);
            #1 {sample_we_i, alarm_active_i, sample_sel_i, sample_data_i} = {1'b1, r[0], 4'(r), 14'($urandom)};
            @(posedge core_clk_i) #1 sample_we_i = 0;
            if (r < 9) {m[r], fr[r]} = {sample_data_i, 1'b1};
            for (int a = 9; a < 28; a++) begin
                u_host.xfer({1'b0, 7'(a), 8'($urandom)}, q);
                `CHK("word", {e, fr}, {q, fresh_o})
                if (a == 23) p24 = 24'(q[13:0]) << 8;
                if (a == 25) `CHK("press24", {2'b0, m[6], m[7][7:0]}, p24 + 24'(q[7:0]))
                k = a / 2 - 5;
                e = 16'h0;
                if (a > 9 && a < 27) begin
                    e = {fr[k], alarm_active_i, k == 8 ? {2'b0, m[k][11:0]} : m[k]};
                    if (k == 7) e = {8'h0, m[k][7:0]};
                    fr[k] = 0;
                end
            end
            // write command must leave the pending address alone
            u_host.xfer({1'b1, 7'h0a, 8'($urandom)}, q);
            `CHK("wr", {16'h0, fr}, {q, fresh_o})
        end
        end_of_test;
    end
endmodule
bind sodr_output_regs sodr_chk u_chk (.*);
